// file: rtl/drive_pkg.sv
// Shared constants and types for the run timing and limits block
package drive_pkg;

    // Register indices; byte address is four times the index
    localparam int IDX_W = 8;
    localparam logic [7:0] IDX_ABORT_PCT = 8'h39;
    localparam logic [7:0] IDX_START_TQ = 8'h3F;
    localparam logic [7:0] IDX_MAX_TQ = 8'h40;
    localparam logic [7:0] IDX_END_TQ = 8'h41;
    localparam logic [7:0] IDX_HOLD_TQ = 8'h42;
    localparam logic [7:0] IDX_ABORT_TIME = 8'h46;
    localparam logic [7:0] IDX_START_PER = 8'h47;
    localparam logic [7:0] IDX_END_PER = 8'h48;
    localparam logic [7:0] IDX_REV_PER = 8'h49;
    localparam logic [7:0] IDX_KEY_HOLD = 8'h4A;
    localparam logic [7:0] IDX_BRAKE_HOLD = 8'h4B;
    localparam logic [7:0] IDX_UFILT = 8'h4C;
    localparam logic [7:0] IDX_SCRATCH0 = 8'h50;
    localparam logic [7:0] IDX_UTHR = 8'h5A;
    localparam logic [7:0] IDX_TEMP_CEIL = 8'h5B;
    localparam logic [7:0] IDX_CTRL = 8'h60;
    localparam logic [7:0] IDX_STATUS = 8'h61;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h62;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h63;
    localparam int SCRATCH_N = 10;

    // Slots of the 16-bit parameter array
    localparam int PAR_N = 14;
    localparam logic [3:0] SL_ABORT_PCT = 4'h0;
    localparam logic [3:0] SL_START_TQ = 4'h1;
    localparam logic [3:0] SL_MAX_TQ = 4'h2;
    localparam logic [3:0] SL_END_TQ = 4'h3;
    localparam logic [3:0] SL_HOLD_TQ = 4'h4;
    localparam logic [3:0] SL_ABORT_TIME = 4'h5;
    localparam logic [3:0] SL_START_PER = 4'h6;
    localparam logic [3:0] SL_END_PER = 4'h7;
    localparam logic [3:0] SL_REV_PER = 4'h8;
    localparam logic [3:0] SL_KEY_HOLD = 4'h9;
    localparam logic [3:0] SL_BRAKE_HOLD = 4'hA;
    localparam logic [3:0] SL_UFILT = 4'hB;
    localparam logic [3:0] SL_UTHR = 4'hC;
    localparam logic [3:0] SL_TEMP_CEIL = 4'hD;
    localparam logic [3:0] SL_NONE = 4'hF;

    // Values after reset, in slot order; torque values are plain defaults
    localparam logic [15:0] RST_TORQUE = 16'h0064;
    localparam logic [15:0] PAR_RST [PAR_N] = '{
        16'h001E, RST_TORQUE, RST_TORQUE, RST_TORQUE, RST_TORQUE,
        16'h00C8, 16'h00C8, 16'h00C8, 16'h000A, 16'h03E8,
        16'h03E8, 16'h0064, 16'h00B9, 16'h0046
    };
    localparam logic [31:0] RST_SCRATCH = 32'h0000_0000;

    // Status and control bit positions
    localparam int ST_RUN = 0;
    localparam int ST_OVERTEMP = 1;
    localparam int ST_BRAKE = 2;
    localparam int ST_STANDSTILL = 3;
    localparam int ST_POWER = 4;
    localparam int CTRL_JOG_FWD = 0;
    localparam int CTRL_JOG_REV = 1;

    // Interrupt events
    localparam int EV_N = 5;
    localparam int EV_RUN_START = 0;
    localparam int EV_RUN_END = 1;
    localparam int EV_ABORT = 2;
    localparam int EV_OVERTEMP = 3;
    localparam int EV_REFUSED = 4;

    // Timing
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 8;
    localparam int MS_CYCLES_DEF = MS_NS / CLK_NS;
    localparam logic [2:0] KEY_STEP_MS = 3'd5;
    localparam int UNDERVOLT_MV = 17500;
    localparam logic [15:0] UNDERVOLT_DV = 16'(UNDERVOLT_MV / 100);
    localparam logic [31:0] PCT_FULL = 32'd100;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_PAUSE = 3'b001,
        PH_START = 3'b010,
        PH_RUN = 3'b011,
        PH_HOLD = 3'b100
    } phase_t;

    typedef struct packed {
        logic [15:0] voltage_dv;
        logic [15:0] temp_c;
        logic [15:0] speed_rpm;
        logic [15:0] target_rpm;
    } meas_t;

    typedef struct packed {
        logic [15:0] torque_limit;
        logic enable;
        logic dir;
        logic brake_release;
    } drive_t;

endpackage : drive_pkg

// file: rtl/drive_run_timing.sv
// Run phase sequencing, limits and AXI4-Lite register file of the drive
//
// Function
// - Startup torque ceiling for set period
// - Then switch to normal maximum torque
// - End-of-run holding torque for set period
// - Afterwards standstill holding torque applies
// - Idle pause on direction reversal
// - Manual run after key held long enough
// - Key hold time writable only at standstill
// - Brake stays released for set period after entry to standstill
// - Average motor voltage over set window
// - Ten 32-bit scratch words, reset zero
// - Status bit 4 from voltage threshold
// - Refuse start unless voltage above threshold
// - Running tolerates sag to 17.5 V
// - Configurable upper temperature limit
// - Abort speed as percent of target
`timescale 1ns/1ps
module drive_run_timing
    import drive_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Measurements and positioning request from the control core
    input wire meas_t meas,
    input wire logic pos_run_req,
    input wire logic pos_run_dir,
    // Manual run keys from pins
    input wire logic key_fwd_pin,
    input wire logic key_rev_pin,
    // Power stage, brake and alarms
    output drive_t drive,
    output logic over_temp,
    output logic irq
);

    function automatic logic [3:0] par_slot(input logic [7:0] idx);
        unique case (idx)
            IDX_ABORT_PCT: par_slot = SL_ABORT_PCT;
            IDX_START_TQ: par_slot = SL_START_TQ;
            IDX_MAX_TQ: par_slot = SL_MAX_TQ;
            IDX_END_TQ: par_slot = SL_END_TQ;
            IDX_HOLD_TQ: par_slot = SL_HOLD_TQ;
            IDX_ABORT_TIME: par_slot = SL_ABORT_TIME;
            IDX_START_PER: par_slot = SL_START_PER;
            IDX_END_PER: par_slot = SL_END_PER;
            IDX_REV_PER: par_slot = SL_REV_PER;
            IDX_KEY_HOLD: par_slot = SL_KEY_HOLD;
            IDX_BRAKE_HOLD: par_slot = SL_BRAKE_HOLD;
            IDX_UFILT: par_slot = SL_UFILT;
            IDX_UTHR: par_slot = SL_UTHR;
            IDX_TEMP_CEIL: par_slot = SL_TEMP_CEIL;
            default: par_slot = SL_NONE;
        endcase
    endfunction : par_slot

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return m;
    endfunction : merge

    function automatic logic is_scratch(input logic [7:0] idx);
        return (idx >= IDX_SCRATCH0) && (idx < IDX_SCRATCH0 + 8'(SCRATCH_N));
    endfunction : is_scratch

    // ---------------- Register storage ----------------
    logic [15:0] par_r [PAR_N];
    logic [31:0] scratch_r [SCRATCH_N];
    logic [1:0] ctrl_r;
    logic [EV_N-1:0] irq_stat_r;
    logic [EV_N-1:0] irq_mask_r;

    // ---------------- AXI4-Lite handshake state ----------------
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic aw_got_r, w_got_r;
    logic [7:0] wr_idx_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    wire aw_hs = awvalid & awready_r;
    wire w_hs = wvalid & wready_r;
    wire b_hs = bvalid_r & bready;
    wire ar_hs = arvalid & arready_r;
    wire r_hs = rvalid_r & rready;
    wire do_wr = aw_got_r & w_got_r & ~bvalid_r;
    wire [3:0] wr_slot = par_slot(wr_idx_r);
    wire wr_scr = is_scratch(wr_idx_r);
    wire [3:0] wr_scr_i = 4'(wr_idx_r - IDX_SCRATCH0);
    wire wr_ctrl = do_wr & (wr_idx_r == IDX_CTRL);
    wire wr_istat = do_wr & (wr_idx_r == IDX_IRQ_STAT);
    wire wr_imask = do_wr & (wr_idx_r == IDX_IRQ_MASK);
    wire wr_hit = (wr_slot != SL_NONE) | wr_scr | (wr_idx_r >= IDX_CTRL && wr_idx_r <= IDX_IRQ_MASK);

    // ---------------- Run state ----------------
    phase_t state_r, state_nxt;
    logic [15:0] phase_ms_r;
    logic [31:0] ms_cnt_r;
    logic ms_tick_r;
    logic last_dir_r;
    logic [15:0] slow_ms_r;
    logic [31:0] acc_r;
    logic [15:0] nsamp_r;
    logic [15:0] avg_r;
    logic power_r;
    logic over_temp_r;
    logic req_prev_r;
    logic [2:0] k_fwd_r, k_rev_r;
    logic [1:0] key_r;
    logic [2:0] step_r;
    logic [15:0] key_steps_r;
    logic [1:0] man_prev_r;
    drive_t drive_r;
    logic irq_r;

    // ---------------- Derived conditions ----------------
    wire standstill = (state_r == PH_IDLE);
    wire [1:0] man_in = key_r | ctrl_r;
    wire man_one = (man_in == 2'b01) | (man_in == 2'b10);
    wire manual_ok = man_one & (key_steps_r >= par_r[SL_KEY_HOLD]);
    wire run_req = pos_run_req | manual_ok;
    wire run_dir = manual_ok ? man_in[CTRL_JOG_REV] : pos_run_dir;
    wire start_ok = power_r & ~over_temp_r;
    wire [31:0] speed_pct = 32'(meas.speed_rpm) * PCT_FULL;
    wire [31:0] limit_pct = 32'(meas.target_rpm) * 32'(par_r[SL_ABORT_PCT]);
    wire too_slow = speed_pct < limit_pct;
    wire abort_run = slow_ms_r > par_r[SL_ABORT_TIME];
    wire sagged = avg_r < UNDERVOLT_DV;
    wire [15:0] ufilt_n = (par_r[SL_UFILT] == 16'h0000) ? 16'h0001 : par_r[SL_UFILT];
    wire [31:0] acc_sum = acc_r + 32'(meas.voltage_dv);
    wire win_done = (nsamp_r + 16'h0001) >= ufilt_n;
    wire refused = run_req & ~req_prev_r & standstill & ~start_ok;
    wire [EV_N-1:0] events;

    assign events[EV_RUN_START] = (state_nxt == PH_START) & (state_r != PH_START);
    assign events[EV_RUN_END] = (state_nxt == PH_HOLD) & (state_r != PH_HOLD);
    assign events[EV_ABORT] = (state_r == PH_RUN) & (abort_run | sagged);
    assign events[EV_OVERTEMP] = (meas.temp_c > par_r[SL_TEMP_CEIL]) & ~over_temp_r;
    assign events[EV_REFUSED] = refused;

    // Hardware set wins over a software clear in the same cycle
    wire [EV_N-1:0] istat_nxt = (irq_stat_r & ~(wr_istat ? wdata_r[EV_N-1:0] : '0)) | events;

    // ---------------- Phase sequencer ----------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PH_IDLE: begin
                if (run_req && start_ok) begin
                    state_nxt = (run_dir != last_dir_r) ? PH_PAUSE : PH_START;
                end
            end
            PH_PAUSE: begin
                if (!run_req) begin
                    state_nxt = PH_IDLE;
                end else if (phase_ms_r >= par_r[SL_REV_PER]) begin
                    state_nxt = PH_START;
                end
            end
            PH_START: begin
                if (!run_req) begin
                    state_nxt = PH_HOLD;
                end else if (phase_ms_r >= par_r[SL_START_PER]) begin
                    state_nxt = PH_RUN;
                end
            end
            PH_RUN: begin
                if (!run_req || abort_run || sagged) begin
                    state_nxt = PH_HOLD;
                end
            end
            PH_HOLD: begin
                if (phase_ms_r >= par_r[SL_END_PER]) begin
                    state_nxt = PH_IDLE;
                end
            end
            default: state_nxt = PH_IDLE;
        endcase
    end

    // Torque ceiling chosen from the phase about to apply
    logic [15:0] torque_nxt;
    always_comb begin
        unique case (state_nxt)
            PH_START: torque_nxt = par_r[SL_START_TQ];
            PH_RUN: torque_nxt = par_r[SL_MAX_TQ];
            PH_HOLD: torque_nxt = par_r[SL_END_TQ];
            default: torque_nxt = par_r[SL_HOLD_TQ];
        endcase
    end

    // Free-running millisecond tick; phase timers are therefore exact to one tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ms_cnt_r <= '0;
            ms_tick_r <= 1'b0;
        end else begin
            ms_tick_r <= (ms_cnt_r == 32'(MS_CYCLES - 1));
            ms_cnt_r <= (ms_cnt_r == 32'(MS_CYCLES - 1)) ? '0 : ms_cnt_r + 32'd1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= PH_IDLE;
            phase_ms_r <= '0;
            last_dir_r <= 1'b0;
            slow_ms_r <= '0;
            req_prev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            req_prev_r <= run_req;
            if (state_nxt != state_r) begin
                phase_ms_r <= '0;
            end else if (ms_tick_r && phase_ms_r != 16'hFFFF) begin
                phase_ms_r <= phase_ms_r + 16'h0001;
            end
            if (state_nxt == PH_START && state_r != PH_START) begin
                last_dir_r <= run_dir;
            end
            if (state_r != PH_RUN || !too_slow) begin
                slow_ms_r <= '0;
            end else if (ms_tick_r && slow_ms_r != 16'hFFFF) begin
                slow_ms_r <= slow_ms_r + 16'h0001;
            end
        end
    end

    // Drive outputs; brake hold measured from entry to standstill
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_r <= '0;
        end else begin
            drive_r.torque_limit <= torque_nxt;
            drive_r.enable <= (state_nxt == PH_START) | (state_nxt == PH_RUN);
            drive_r.dir <= (state_nxt == PH_START && state_r != PH_START) ? run_dir : drive_r.dir;
            if (state_nxt != PH_IDLE) begin
                drive_r.brake_release <= 1'b1;
            end else if (state_r == PH_IDLE && phase_ms_r >= par_r[SL_BRAKE_HOLD]) begin
                drive_r.brake_release <= 1'b0;
            end
        end
    end

    // ---------------- Motor voltage averaging and temperature ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_r <= '0;
            nsamp_r <= '0;
            avg_r <= '0;
            power_r <= 1'b0;
            over_temp_r <= 1'b0;
        end else begin
            if (ms_tick_r) begin
                if (win_done) begin
                    avg_r <= 16'(acc_sum / 32'(ufilt_n));
                    acc_r <= '0;
                    nsamp_r <= '0;
                end else begin
                    acc_r <= acc_sum;
                    nsamp_r <= nsamp_r + 16'h0001;
                end
            end
            power_r <= avg_r > par_r[SL_UTHR];
            over_temp_r <= meas.temp_c > par_r[SL_TEMP_CEIL];
        end
    end

    // ---------------- Manual keys ----------------
    // Three-stage synchroniser; a level counts once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            k_fwd_r <= '0;
            k_rev_r <= '0;
            key_r <= '0;
        end else begin
            k_fwd_r <= {k_fwd_r[1:0], key_fwd_pin};
            k_rev_r <= {k_rev_r[1:0], key_rev_pin};
            if (k_fwd_r[1] == k_fwd_r[2]) begin
                key_r[CTRL_JOG_FWD] <= k_fwd_r[2];
            end
            if (k_rev_r[1] == k_rev_r[2]) begin
                key_r[CTRL_JOG_REV] <= k_rev_r[2];
            end
        end
    end

    // Hold time counted in 5 ms steps; any change of key pattern restarts it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_r <= '0;
            key_steps_r <= '0;
            man_prev_r <= '0;
        end else begin
            man_prev_r <= man_in;
            if (!man_one || man_in != man_prev_r) begin
                step_r <= '0;
                key_steps_r <= '0;
            end else if (ms_tick_r) begin
                if (step_r == KEY_STEP_MS - 3'd1) begin
                    step_r <= '0;
                    if (key_steps_r != 16'hFFFF) begin
                        key_steps_r <= key_steps_r + 16'h0001;
                    end
                end else begin
                    step_r <= step_r + 3'd1;
                end
            end
        end
    end

    // ---------------- Register writes ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < PAR_N; i++) begin
                par_r[i] <= PAR_RST[i];
            end
            for (int i = 0; i < SCRATCH_N; i++) begin
                scratch_r[i] <= RST_SCRATCH;
            end
        end else if (do_wr) begin
            for (int i = 0; i < PAR_N; i++) begin
                // Hold time change is dropped unless the drive stands still
                if (wr_slot == 4'(i) && (wr_slot != SL_KEY_HOLD || standstill)) begin
                    par_r[i] <= 16'(merge({16'h0000, par_r[i]}, wdata_r, wstrb_r));
                end
            end
            if (wr_scr) begin
                scratch_r[wr_scr_i] <= merge(scratch_r[wr_scr_i], wdata_r, wstrb_r);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= '0;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            if (wr_ctrl && wstrb_r[0]) begin
                ctrl_r <= wdata_r[1:0];
            end
            if (wr_imask && wstrb_r[0]) begin
                irq_mask_r <= wdata_r[EV_N-1:0];
            end
            irq_stat_r <= istat_nxt;
            irq_r <= |(istat_nxt & irq_mask_r);
        end
    end

    // ---------------- AXI4-Lite write channel ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            wr_idx_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            if (aw_hs) begin
                awready_r <= 1'b0;
                aw_got_r <= 1'b1;
                wr_idx_r <= awaddr[9:2];
            end
            if (w_hs) begin
                wready_r <= 1'b0;
                w_got_r <= 1'b1;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (do_wr) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (b_hs) begin
                bvalid_r <= 1'b0;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // ---------------- AXI4-Lite read channel ----------------
    wire [7:0] rd_idx = araddr[9:2];
    wire [3:0] rd_slot = par_slot(rd_idx);
    wire [3:0] rd_scr_i = 4'(rd_idx - IDX_SCRATCH0);
    wire [31:0] status_w = {avg_r, 8'h00, 3'(state_r), power_r, standstill,
                            drive_r.brake_release, over_temp_r, drive_r.enable};
    logic [31:0] rd_val;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        rd_val = '0;
        if (rd_slot != SL_NONE) begin
            rd_val = {16'h0000, par_r[rd_slot]};
        end else if (is_scratch(rd_idx)) begin
            rd_val = scratch_r[rd_scr_i];
        end else if (rd_idx == IDX_CTRL) begin
            rd_val = {30'h0, ctrl_r};
        end else if (rd_idx == IDX_STATUS) begin
            rd_val = status_w;
        end else if (rd_idx == IDX_IRQ_STAT) begin
            rd_val = 32'(irq_stat_r);
        end else if (rd_idx == IDX_IRQ_MASK) begin
            rd_val = 32'(irq_mask_r);
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else begin
            if (ar_hs) begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= rd_val;
                rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (r_hs) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign drive = drive_r;
    assign over_temp = over_temp_r;
    assign irq = irq_r;

endmodule : drive_run_timing

// file: tb/drive_motor_model.sv
// Motor stage and manual key model facing the drive block
`timescale 1ns/1ps
module drive_motor_model
    import drive_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Bench settings
    input wire logic [15:0] volt,
    input wire logic [15:0] temp,
    input wire logic [1:0] keys,
    // Drive side
    input wire drive_t drive,
    output meas_t meas,
    output logic key_fwd_pin,
    output logic key_rev_pin
);
    // Shaft reaches target at once, so the slow-run abort never trips
    assign meas = {volt, temp, drive.enable === 1'h1 ? 16'h0BB8 : 16'h0000, 16'h0BB8};
    assign key_fwd_pin = keys[0];
    assign key_rev_pin = keys[1];
endmodule : drive_motor_model

// file: tb/drive_run_timing_checker.sv
// Bus timing and run interlock assertions of the drive block
`timescale 1ns/1ps
module drive_run_timing_checker
    import drive_pkg::*;
#(
    parameter int MS_CYCLES = 10
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    // Drive side
    input wire meas_t meas,
    input wire drive_t drive,
    input wire logic over_temp
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wr_resp_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response not two cycles on");
    wr_busy_a: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while busy");
    aw_busy_a: assert property (awvalid && awready |=> !awready [*2])
        else $error("address ready too soon");
    rd_resp_a: assert property (arvalid && arready |=> rvalid && !arready)
        else $error("read response not next cycle");
    rd_done_a: assert property (rvalid && rready |=> !rvalid)
        else $error("read data held after handshake");
    // Lowest legal ceiling is 10 C, so a colder reading never flags
    temp_ok_a: assert property (meas.temp_c < 16'h000A |=> !over_temp)
        else $error("overtemp below limit");
    brake_run_a: assert property (drive.enable |-> drive.brake_release)
        else $error("brake engaged while driving");
    dir_hold_a: assert property (drive.enable [*2] |-> $stable(drive.dir))
        else $error("direction flipped while driving");
endmodule : drive_run_timing_checker

bind drive_run_timing drive_run_timing_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.aclk, .aresetn,
    .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .rready,
    .meas, .drive, .over_temp);

// file: tb/drive_run_timing_test.sv
// Self-checking bench of the drive run timing block
`timescale 1ns/1ps
module drive_run_timing_test
    import drive_pkg::*;
;
    localparam int MS = 10;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
    logic pos_run_req = 1'h0, bready = 1'h1, rready = 1'h1;
    logic awready, wready, bvalid, arready, rvalid, over_temp, irq, key_fwd_pin, key_rev_pin;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0] bresp, rresp, keys = 2'h0;
    logic [15:0] volt = 16'h00F0, temp = 16'h0005;
    logic [33:0] exp_q [$];
    int miscompares = 0, n_checks = 0, seed = 14, i;
    logic [23:0] rt [10] = '{24'h4600C8, 24'h4700C8, 24'h4800C8, 24'h49000A, 24'h4A03E8,
        24'h4B03E8, 24'h4C0064, 24'h5A00B9, 24'h5B0046, 24'h39001E};
    logic [23:0] wt [7] = '{24'h3F0011, 24'h400022, 24'h410033, 24'h420044, 24'h47000A,
        24'h48000A, 24'h4B000A};
    meas_t meas;
    drive_t drive;
    always #4 aclk = ~aclk;
    drive_run_timing #(.MS_CYCLES(MS)) u_drive_run_timing (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .meas, .pos_run_req,
        .pos_run_dir(1'h0), .key_fwd_pin, .key_rev_pin, .drive, .over_temp, .irq);
    drive_motor_model u_drive_motor_model (.aclk, .volt, .temp, .keys, .drive, .meas,
        .key_fwd_pin, .key_rev_pin);
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task automatic tmo;
        miscompares++;
        tally_and_finish();
    endtask : tmo
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n = 0;
        awaddr <= {2'h0, a, 2'h0};
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (n > 50) tmo();
        end while (!bvalid);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
        int n = 0;
        exp_q.push_back({r, v});
        araddr <= {2'h0, a, 2'h0};
        arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'h0;
            if (n > 50) tmo();
        end while (!rvalid);
    endtask : rd
    task automatic wait_en(input logic v);
        int n = 0;
        while (drive.enable !== v) begin
            @(posedge aclk);
            n++;
            if (n > 3000) tmo();
        end
    endtask : wait_en
    always @(posedge aclk) begin
        if (rvalid && rready) check({rresp, rdata}, exp_q.pop_front());
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        for (i = 0; i < 10; i++) rd(rt[i][23:16], {16'h0, rt[i][15:0]}, 2'h0);
        for (i = 0; i < 10; i++) begin
            d = $random(seed);
            rd(8'h50 + 8'(i), 32'h0, 2'h0);
            wr(8'h50 + 8'(i), d);
            rd(8'h50 + 8'(i), d, 2'h0);
        end
        rd(8'h01, 32'h0, RESP_SLVERR);
        for (i = 0; i < 7; i++) wr(wt[i][23:16], {16'h0, wt[i][15:0]});
        // Average is still zero, so this request must be refused
        pos_run_req <= 1'h1;
        repeat (5) @(posedge aclk);
        check(drive.enable, 1'h0);
        check(irq, 1'h0);
        wr(8'h63, 32'h10);
        repeat (2) @(posedge aclk);
        check(irq, 1'h1);
        wr(8'h62, 32'h10);
        repeat (2) @(posedge aclk);
        check(irq, 1'h0);
        wait_en(1'h1);
        check(drive.torque_limit, 16'h0011);
        repeat (10 * MS - 9) @(posedge aclk);
        check(drive.torque_limit, 16'h0011);
        repeat (20) @(posedge aclk);
        check(drive.torque_limit, 16'h0022);
        wr(8'h4A, 32'h2);
        pos_run_req <= 1'h0;
        repeat (3) @(posedge aclk);
        check(drive.torque_limit, 16'h0033);
        repeat (12 * MS) @(posedge aclk);
        check(drive.torque_limit, 16'h0044);
        check(drive.brake_release, 1'h1);
        repeat (12 * MS) @(posedge aclk);
        check(drive.brake_release, 1'h0);
        rd(8'h4A, 32'h3E8, 2'h0);
        wr(8'h4A, 32'h2);
        rd(8'h4A, 32'h2, 2'h0);
        // Reverse key after a forward run also walks through the reversal pause
        keys <= 2'h2;
        repeat (30) @(posedge aclk);
        check(drive.enable, 1'h0);
        wait_en(1'h1);
        check(drive.dir, 1'h1);
        keys <= 2'h0;
        wait_en(1'h0);
        temp <= 16'h0050;
        repeat (4) @(posedge aclk);
        check(over_temp, 1'h1);
        tally_and_finish();
    end
endmodule : drive_run_timing_test
